// ===== hw/mfcs_pkg.sv
// shared constants and carrier types for the MAC flow/config/status block
package mfcs_pkg;

  // register offsets on the host bus
  localparam logic [4:0] OFF_JAM_STATUS = 5'h17;
  localparam logic [4:0] OFF_FRAME_LOW  = 5'h18;
  localparam logic [4:0] OFF_FRAME_HIGH = 5'h19;
  localparam logic [4:0] OFF_FLOW       = 5'h1A;
  localparam logic [4:0] OFF_MAC        = 5'h1B;

  // reset values
  localparam logic [5:0] JAM_RST        = 6'h19;
  localparam logic [7:0] FRAME_LOW_RST  = 8'h00;
  localparam logic [2:0] FRAME_HIGH_RST = 3'h6;
  localparam logic [7:0] FLOW_RST       = 8'h07;
  localparam logic [7:0] MAC_RST        = 8'h00;

  // device status bit positions
  localparam int ST_BIG_ENDIAN  = 7;
  localparam int ST_REMOTE_DONE = 6;
  localparam int ST_READ_READY  = 5;
  localparam int ST_DEV_READY   = 4;
  localparam int ST_SPEED       = 2;
  localparam int ST_DUPLEX      = 1;
  localparam int ST_LINK        = 0;

  // flow control bit positions
  localparam int FC_ENABLE  = 7;
  localparam int FC_BP      = 6;
  localparam int FC_HW_MSB  = 5;

  // mac config bit positions
  localparam int MC_DUPLEX  = 7;
  localparam int MC_NO_LEAK = 6;
  localparam int MC_B2B     = 5;
  localparam int MC_EXT_PHY = 4;
  localparam int MC_TAG     = 3;
  localparam int MC_CAPTURE = 2;
  localparam int MC_SHORT   = 1;
  localparam int MC_ZERO    = 0;

  // frame filter and back-off figures
  localparam logic [15:0] TAG_TYPE          = 16'h8100;
  localparam logic [11:0] NULL_VID          = 12'h000;
  localparam logic [9:0]  CAPTURE_FIRST     = 10'h002;
  localparam logic [9:0]  CAPTURE_SECOND    = 10'h000;
  localparam logic [9:0]  SHORT_MASK        = 10'h003;
  localparam logic [4:0]  BACKOFF_EXP_LIMIT = 5'h0A;
  localparam logic [4:0]  ATTEMPT_MAX       = 5'h1F;

  typedef struct packed {
    logic [4:0] addr;
    logic       wrStb;
    logic       rdStb;
    logic [7:0] wrData;
  } mfcs_host_t;

  typedef struct packed {
    logic speed100;
    logic fullDuplex;
    logic linkUp;
  } mfcs_phy_t;

  typedef struct packed {
    logic [5:0]  jamLimit;
    logic [10:0] maxFrameSize;
    logic        flowControlEnable;
    logic        backPressureActive;
    logic [5:0]  highWaterPages;
    logic        macFullDuplex;
    logic        leakageAllowed;
    logic        backToBackTx;
    logic        externalPhySelect;
    logic        tagFilterEnable;
  } mfcs_cfg_t;

  typedef struct packed {
    logic captureEffect;
    logic shortBackoff;
    logic zeroBackoff;
  } mfcs_test_t;

endpackage : mfcs_pkg

// ===== hw/mfcs_backoff.sv
// back-off slot generator with the three test modes
module mfcs_backoff
  import mfcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire mfcs_test_t testMode,
  input  wire logic       collisionEvent,
  input  wire logic       txDone,
  input  wire logic [9:0] randomValue,
  output logic [9:0]      backoffSlots,
  output logic            backoffValid
);

  typedef struct packed {
    logic [4:0] attempt;
    logic [9:0] slots;
    logic       valid;
  } mfcs_bo_state_t;

  mfcs_bo_state_t st_q, st_d;

  // truncated binary exponential range for a given attempt number
  function automatic logic [9:0] rangeMask(input logic [4:0] n);
    logic [4:0] e;
    e = (n > BACKOFF_EXP_LIMIT) ? BACKOFF_EXP_LIMIT : n;
    rangeMask = 10'((11'h001 << e) - 11'h001);
  endfunction : rangeMask

  always_comb begin
    logic [4:0] n;
    n = (st_q.attempt == ATTEMPT_MAX) ? st_q.attempt
                                      : 5'(st_q.attempt + 5'h01);
    st_d = st_q;
    st_d.valid = 1'b0;
    if (txDone) begin
      st_d.attempt = 5'h00;
    end else if (collisionEvent) begin
      st_d.attempt = n;
      st_d.valid   = 1'b1;
      if (testMode.zeroBackoff) begin
        st_d.slots = 10'h000;
      end else if (testMode.shortBackoff) begin
        st_d.slots = randomValue & rangeMask(n) & SHORT_MASK;
      end else if (testMode.captureEffect && n == 5'h01) begin
        st_d.slots = CAPTURE_FIRST;
      end else if (testMode.captureEffect && n == 5'h02) begin
        st_d.slots = CAPTURE_SECOND;
      end else begin
        st_d.slots = randomValue & rangeMask(n);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign backoffSlots = st_q.slots;
  assign backoffValid = st_q.valid;

  // keyed on the attempt counter, so any spacing after txDone is covered
  capture_first_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    collisionEvent && !txDone && st_q.attempt == 5'h00
      && testMode.captureEffect && !testMode.shortBackoff
      && !testMode.zeroBackoff
      |=> backoffValid && backoffSlots == CAPTURE_FIRST)
    else $error("capture first back-off not two slots");

  capture_second_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    collisionEvent && !txDone && st_q.attempt == 5'h01
      && testMode.captureEffect && !testMode.shortBackoff
      && !testMode.zeroBackoff
      |=> backoffValid && backoffSlots == CAPTURE_SECOND)
    else $error("capture second back-off not zero");

endmodule : mfcs_backoff

// ===== hw/mfcs_regs.sv
// MAC flow control, configuration and device status register group
// Functional notes
// - write-only six-bit jam limit at 0x17, reset 19h, upper bits zero
// - status bit 7 is one when byte-order register is nonzero
// - status bit 6 mirrors interrupt status bit 6, remote done
// - status bit 5 set when read port data is ready
// - status bit 4 ready unless reset, power saving or config load
// - status bits 2..0 give PHY speed, duplex, link; bit 3 zero
// - eleven-bit max frame size over two registers, default 1536
// - flow control register bit 7 enables flow control, reset off
// - bit 6 enables back-pressure, ignored in full duplex
// - bits 5:0 high-water free pages, register resets to 07h
// - mac config bit 7 reads real duplex; write ORed with tx config
// - internal PHY in use: duplex comes from the PHY only
// - bit 6 zero: leak after jam-limit collisions; one: never leak
// - bit 5 allows back-to-back transmit starts without waiting
// - bit 4 selects media: zero internal PHY, one external PHY
// - bit 3: accept only tagged frames with matching or null id
// - capture test: first back-off 2 slots, second 0, then normal
// - short test mode limits back-off to 0..3 slots
// - zero test mode forces back-off to zero slots
module mfcs_regs
  import mfcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire mfcs_host_t hostReq,
  output logic [7:0]      hostRdData,
  output logic            hostRdValid,
  input  wire logic [7:0] byteOrder,
  input  wire logic       remoteTransferDone,
  input  wire logic       readPortReady,
  input  wire logic       inResetState,
  input  wire logic       powerSaving,
  input  wire logic       configLoading,
  input  wire mfcs_phy_t  phyStatus,
  input  wire logic       txConfigDuplex,
  input  wire logic       collisionEvent,
  input  wire logic       txDone,
  input  wire logic [9:0] randomValue,
  input  wire logic       frameCheck,
  input  wire logic [15:0] frameType,
  input  wire logic [11:0] frameVlanId,
  input  wire logic [11:0] hostVlanId,
  output mfcs_cfg_t       cfg,
  output logic            backPressureLeak,
  output logic            frameReject,
  output logic            frameRejectValid,
  output logic [9:0]      backoffSlots,
  output logic            backoffValid
);

  typedef struct packed {
    logic [5:0] jamLimit;
    logic [7:0] frameLow;
    logic [2:0] frameHigh;
    logic [7:0] flow;
    logic [7:0] mac;
    logic [5:0] collCount;
    logic       leak;
    logic       reject;
    logic       rejectValid;
    logic [7:0] rdData;
    logic       rdValid;
    mfcs_cfg_t  cfg;
  } mfcs_state_t;

  mfcs_state_t st_q, st_d;

  logic       devReady;
  logic       effDuplex;
  logic       bpActive;
  logic [7:0] statusWord;
  logic [7:0] macReadWord;
  logic       wrJam, wrLow, wrHigh, wrFlow, wrMac;
  mfcs_test_t testModeSel;

  function automatic logic hit(input mfcs_host_t r, input logic [4:0] off);
    hit = r.addr == off;
  endfunction : hit

  // the status word is combinational so it stays readable in any state
  assign devReady = !(inResetState || powerSaving || configLoading);

  // the external-PHY duplex path ORs both written bits
  assign effDuplex = st_q.mac[MC_EXT_PHY]
                   ? (st_q.mac[MC_DUPLEX] || txConfigDuplex)
                   : phyStatus.fullDuplex;

  assign bpActive = st_q.flow[FC_BP] && !effDuplex;

  always_comb begin
    statusWord                 = 8'h00;
    statusWord[ST_BIG_ENDIAN]  = |byteOrder;
    statusWord[ST_REMOTE_DONE] = remoteTransferDone;
    statusWord[ST_READ_READY]  = readPortReady;
    statusWord[ST_DEV_READY]   = devReady;
    statusWord[ST_SPEED]       = phyStatus.speed100;
    statusWord[ST_DUPLEX]      = phyStatus.fullDuplex;
    statusWord[ST_LINK]        = phyStatus.linkUp;
  end

  always_comb begin
    macReadWord            = st_q.mac;
    macReadWord[MC_DUPLEX] = effDuplex;
  end

  assign wrJam  = hostReq.wrStb && hit(hostReq, OFF_JAM_STATUS);
  assign wrLow  = hostReq.wrStb && hit(hostReq, OFF_FRAME_LOW);
  assign wrHigh = hostReq.wrStb && hit(hostReq, OFF_FRAME_HIGH);
  assign wrFlow = hostReq.wrStb && hit(hostReq, OFF_FLOW);
  assign wrMac  = hostReq.wrStb && hit(hostReq, OFF_MAC);

  always_comb begin
    logic [5:0] nextCount;
    nextCount = 6'(st_q.collCount + 6'h01);
    st_d = st_q;
    st_d.leak        = 1'b0;
    st_d.rejectValid = 1'b0;
    st_d.rdValid     = 1'b0;

    // register writes
    if (wrJam) begin
      st_d.jamLimit = hostReq.wrData[5:0];
    end
    if (wrLow) begin
      st_d.frameLow = hostReq.wrData;
    end
    if (wrHigh) begin
      st_d.frameHigh = hostReq.wrData[2:0];
    end
    if (wrFlow) begin
      st_d.flow = hostReq.wrData;
    end
    if (wrMac) begin
      st_d.mac = hostReq.wrData;
    end

    // reads: jam limit is write-only, the same offset returns status
    if (hostReq.rdStb) begin
      st_d.rdValid = 1'b1;
      unique case (hostReq.addr)
        OFF_JAM_STATUS: st_d.rdData = statusWord;
        OFF_FRAME_LOW:  st_d.rdData = st_q.frameLow;
        OFF_FRAME_HIGH: st_d.rdData = {5'h00, st_q.frameHigh};
        OFF_FLOW:       st_d.rdData = st_q.flow;
        OFF_MAC:        st_d.rdData = macReadWord;
        default:        st_d.rdData = 8'h00;
      endcase
    end

    // consecutive collisions while jamming; a good frame restarts the run
    if (txDone || !bpActive) begin
      st_d.collCount = 6'h00;
    end else if (collisionEvent) begin
      if (!st_q.mac[MC_NO_LEAK] && nextCount >= st_q.jamLimit) begin
        st_d.leak      = 1'b1;
        st_d.collCount = 6'h00;
      end else if (nextCount != 6'h00) begin
        st_d.collCount = nextCount; // saturate rather than wrap
      end
    end

    // tag filter verdict, one cycle after the check strobe
    if (frameCheck) begin
      st_d.rejectValid = 1'b1;
      st_d.reject = st_q.mac[MC_TAG]
                 && (frameType != TAG_TYPE
                     || (frameVlanId != hostVlanId
                         && frameVlanId != NULL_VID));
    end

    // registered view of the effective configuration
    st_d.cfg.jamLimit           = st_q.jamLimit;
    st_d.cfg.maxFrameSize       = {st_q.frameHigh, st_q.frameLow};
    st_d.cfg.flowControlEnable  = st_q.flow[FC_ENABLE];
    st_d.cfg.backPressureActive = bpActive;
    st_d.cfg.highWaterPages     = st_q.flow[FC_HW_MSB:0];
    st_d.cfg.macFullDuplex      = effDuplex;
    st_d.cfg.leakageAllowed     = !st_q.mac[MC_NO_LEAK];
    st_d.cfg.backToBackTx       = st_q.mac[MC_B2B];
    st_d.cfg.externalPhySelect  = st_q.mac[MC_EXT_PHY];
    st_d.cfg.tagFilterEnable    = st_q.mac[MC_TAG];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q           <= '0;
      st_q.jamLimit  <= JAM_RST;
      st_q.frameLow  <= FRAME_LOW_RST;
      st_q.frameHigh <= FRAME_HIGH_RST;
      st_q.flow      <= FLOW_RST;
      st_q.mac       <= MAC_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign testModeSel = '{captureEffect: st_q.mac[MC_CAPTURE],
                         shortBackoff:  st_q.mac[MC_SHORT],
                         zeroBackoff:   st_q.mac[MC_ZERO]};

  // test modes only shape back-off; normal traffic expects them low
  mfcs_backoff u_backoff (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .testMode       (testModeSel),
    .collisionEvent (collisionEvent),
    .txDone         (txDone),
    .randomValue    (randomValue),
    .backoffSlots   (backoffSlots),
    .backoffValid   (backoffValid)
  );

  assign hostRdData       = st_q.rdData;
  assign hostRdValid      = st_q.rdValid;
  assign cfg              = st_q.cfg;
  assign backPressureLeak = st_q.leak;
  assign frameReject      = st_q.reject;
  assign frameRejectValid = st_q.rejectValid;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence statusReadSeq;
    hostReq.rdStb && hostReq.addr == OFF_JAM_STATUS;
  endsequence

  sequence jamWriteSeq;
    hostReq.wrStb && hostReq.addr == OFF_JAM_STATUS;
  endsequence

  sequence frameWriteSeq;
    hostReq.wrStb && hostReq.addr == OFF_FRAME_LOW;
  endsequence

  sequence flowWriteSeq;
    hostReq.wrStb && hostReq.addr == OFF_FLOW;
  endsequence

  status_endian_a: assert property (
    statusReadSeq |=> hostRdValid
      && hostRdData[ST_BIG_ENDIAN] == $past(|byteOrder)
      && hostRdData[3] == 1'b0)
    else $error("status endian bit wrong");

  status_ready_a: assert property (
    statusReadSeq |=> hostRdData[ST_DEV_READY]
      == !($past(inResetState) || $past(powerSaving)
           || $past(configLoading)))
    else $error("device ready bit wrong");

  status_mirror_a: assert property (
    statusReadSeq |=> hostRdData[ST_REMOTE_DONE] == $past(remoteTransferDone)
      && hostRdData[ST_READ_READY] == $past(readPortReady)
      && hostRdData[2:0] == $past({phyStatus.speed100, phyStatus.fullDuplex,
                                   phyStatus.linkUp}))
    else $error("status mirror bits wrong");

  jam_limit_a: assert property (
    jamWriteSeq ##1 !hostReq.wrStb ##1 1'b1 |->
      cfg.jamLimit == $past(hostReq.wrData[5:0], 2))
    else $error("jam limit not stored");

  frame_size_a: assert property (
    frameWriteSeq ##1 !hostReq.wrStb ##1 1'b1 |->
      cfg.maxFrameSize[7:0] == $past(hostReq.wrData, 2))
    else $error("frame size low not stored");

  bp_full_duplex_a: assert property (
    effDuplex && !hostReq.wrStb |=> !cfg.backPressureActive)
    else $error("back-pressure active in full duplex");

  duplex_internal_a: assert property (
    !st_q.mac[MC_EXT_PHY] && !hostReq.wrStb |=>
      cfg.macFullDuplex == $past(phyStatus.fullDuplex))
    else $error("internal phy duplex not followed");

  mac_duplex_read_a: assert property (
    hostReq.rdStb && hostReq.addr == OFF_MAC && st_q.mac[MC_EXT_PHY]
      |=> hostRdData[MC_DUPLEX]
          == ($past(st_q.mac[MC_DUPLEX]) || $past(txConfigDuplex)))
    else $error("mac duplex read wrong");

  no_leak_a: assert property (
    st_q.mac[MC_NO_LEAK] |=> !backPressureLeak)
    else $error("leak with leakage disabled");

  leak_count_a: assert property (
    collisionEvent && bpActive && !txDone && !st_q.mac[MC_NO_LEAK]
      && 6'(st_q.collCount + 6'h01) >= st_q.jamLimit
      |=> backPressureLeak && st_q.collCount == 6'h00)
    else $error("leak missing at jam limit");

  tag_reject_a: assert property (
    frameCheck && st_q.mac[MC_TAG] && frameType != TAG_TYPE
      |=> frameRejectValid && frameReject)
    else $error("untagged frame accepted");

  tag_null_a: assert property (
    frameCheck && frameType == TAG_TYPE && frameVlanId == NULL_VID
      |=> frameRejectValid && !frameReject)
    else $error("null vlan id rejected");

  zero_backoff_a: assert property (
    collisionEvent && !txDone && st_q.mac[MC_ZERO]
      |=> backoffValid && backoffSlots == 10'h000)
    else $error("zero back-off not zero");

  short_backoff_a: assert property (
    collisionEvent && !txDone && st_q.mac[MC_SHORT]
      |=> backoffValid && backoffSlots <= 10'h003)
    else $error("short back-off above three slots");

  flow_store_a: assert property (
    flowWriteSeq ##1 !hostReq.wrStb ##1 1'b1
      |-> cfg.highWaterPages == $past(hostReq.wrData[5:0], 2)
          && cfg.flowControlEnable == $past(hostReq.wrData[FC_ENABLE], 2))
    else $error("flow control register not stored");

  frame_high_a: assert property (
    hostReq.rdStb && hostReq.addr == OFF_FRAME_HIGH
      |=> hostRdValid && hostRdData[7:3] == 5'h00
          && hostRdData[2:0] == $past(st_q.frameHigh))
    else $error("frame size high read wrong");

  flow_read_a: assert property (
    hostReq.rdStb && hostReq.addr == OFF_FLOW
      |=> hostRdValid && hostRdData == $past(st_q.flow))
    else $error("flow control read wrong");

  duplex_external_a: assert property (
    st_q.mac[MC_EXT_PHY] && !hostReq.wrStb
      |=> cfg.macFullDuplex
          == ($past(st_q.mac[MC_DUPLEX]) || $past(txConfigDuplex)))
    else $error("external phy duplex not ored");

  leak_idle_a: assert property (
    !bpActive |=> !backPressureLeak && st_q.collCount == 6'h00)
    else $error("leak or count while not back-pressuring");

  tag_mismatch_a: assert property (
    frameCheck && st_q.mac[MC_TAG] && frameType == TAG_TYPE
      && frameVlanId != hostVlanId && frameVlanId != NULL_VID
      |=> frameRejectValid && frameReject)
    else $error("mismatched vlan id accepted");

  tag_off_a: assert property (
    frameCheck && !st_q.mac[MC_TAG] |=> frameRejectValid && !frameReject)
    else $error("frame rejected with filter off");

endmodule : mfcs_regs

// ===== tb/mfcs_host_model.sv
// host processor model driving the block's register bus
module mfcs_host_model
  import mfcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] hostRdData,
  input  wire logic       hostRdValid,
  output mfcs_host_t      hostReq,
  output logic            busHung
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap;
  initial begin
    hostReq = '0;
    busHung = 1'b0;
    gap = 0;
  end
  // one-cycle write strobe; idle gap lets the bench play a slow host
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    hostReq = '{addr: a, wrStb: 1'b1, rdStb: 1'b0, wrData: d};
    @(negedge clk);
    hostReq.wrStb = 1'b0;
    hostReq.wrData = ~d;
  endtask : wr
  // read pulse, then a bounded wait for the answer
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    int k;
    repeat (gap) @(negedge clk);
    @(negedge clk);
    hostReq = '{addr: a, wrStb: 1'b0, rdStb: 1'b1, wrData: 8'h00};
    @(negedge clk);
    hostReq.rdStb = 1'b0;
    k = 0;
    while (hostRdValid !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    d = hostRdData;
    if (k == 4) busHung = 1'b1;
  endtask : rd
endmodule : mfcs_host_model

// ===== tb/mfcs_regs_tb_top.sv
// self-checking bench for the flow, config and status register group
`define CHK(nm, ex, got) \
  begin \
    nChecks++; \
    if ((got) !== (ex)) begin \
      badCount++; \
      $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module mfcs_regs_tb_top
  import mfcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sysRst, rdValid, rtDone, rpReady, inRst, pwrSave;
  logic        cfgLoad, txCfgDup, coll, txDone, frChk, bpLeak;
  logic        frRej, frRejV, boValid, busHung;
  logic [7:0]  rdData, byteOrder, rv, jamM, frLM, frHM, flwM, macM;
  logic [9:0]  rnd, boSlots;
  logic [15:0] frType;
  logic [11:0] frVid, hostVid;
  logic [31:0] seed, r;
  mfcs_host_t  hostReq;
  mfcs_phy_t   phy;
  mfcs_cfg_t   cfg;
  int          badCount, nChecks, att, cnt;
  logic [7:0]  modes [4] = '{8'h04, 8'h02, 8'h01, 8'h00};

  mfcs_regs u_dut (.clk(clk), .sys_rst(sysRst), .hostReq(hostReq),
    .hostRdData(rdData), .hostRdValid(rdValid), .byteOrder(byteOrder),
    .remoteTransferDone(rtDone), .readPortReady(rpReady),
    .inResetState(inRst), .powerSaving(pwrSave), .configLoading(cfgLoad),
    .phyStatus(phy), .txConfigDuplex(txCfgDup), .collisionEvent(coll),
    .txDone(txDone), .randomValue(rnd), .frameCheck(frChk),
    .frameType(frType), .frameVlanId(frVid), .hostVlanId(hostVid),
    .cfg(cfg), .backPressureLeak(bpLeak), .frameReject(frRej),
    .frameRejectValid(frRejV), .backoffSlots(boSlots),
    .backoffValid(boValid));
  mfcs_host_model u_host (.clk(clk), .hostRdData(rdData),
    .hostRdValid(rdValid), .hostReq(hostReq), .busHung(busHung));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : reportAndStop

  task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
    u_host.rd(a, rv);
    `CHK("read", e, rv)
  endtask : rdChk

  task automatic regWr(input logic [4:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    case (a)
      OFF_JAM_STATUS: jamM = {2'b00, d[5:0]};
      OFF_FRAME_LOW:  frLM = d;
      OFF_FRAME_HIGH: frHM = {5'h00, d[2:0]};
      OFF_FLOW:       flwM = d;
      OFF_MAC:        macM = d;
      default:        ;
    endcase
  endtask : regWr

  function automatic logic dupM();
    return macM[4] ? (macM[7] | txCfgDup) : phy.fullDuplex;
  endfunction : dupM

  // cfg lags the registers by one edge, so let two edges pass first
  task automatic allChk();
    mfcs_cfg_t e;
    repeat (2) @(negedge clk);
    e = '{jamM[5:0], {frHM[2:0], frLM}, flwM[7], flwM[6] & ~dupM(),
          flwM[5:0], dupM(), ~macM[6], macM[5], macM[4], macM[3]};
    `CHK("cfg", e, cfg)
    rdChk(OFF_FRAME_LOW, frLM);
    rdChk(OFF_FRAME_HIGH, frHM);
    rdChk(OFF_FLOW, flwM);
    rdChk(OFF_MAC, {dupM(), macM[6:0]});
  endtask : allChk

  task automatic txd();
    txDone = 1'b1;
    @(negedge clk);
    txDone = 1'b0;
    att = 0;
  endtask : txd

  // collision (c=1) or frame check (c=0), results watched for 3 cycles
  task automatic fire(input logic c);
    logic       lk, ej, rj, bp;
    logic [9:0] sl, es;
    @(negedge clk);
    r = xs();
    rnd = r[9:0];
    coll = c;
    frChk = ~c;
    lk = 1'b0;
    sl = 'x;
    rj = 'x;
    @(negedge clk);
    coll = 1'b0;
    frChk = 1'b0;
    repeat (3) begin
      lk = lk | bpLeak;
      if (boValid === 1'b1) sl = boSlots;
      if (frRejV === 1'b1) rj = frRej;
      @(negedge clk);
    end
    if (c) begin
      att = (att < 31) ? att + 1 : att;
      if (macM[0]) es = 10'h000;
      else if (macM[1]) es = rnd & 10'h003
        & ((10'h001 << ((att < 10) ? att : 10)) - 10'h001);
      else if (macM[2] && att == 1) es = 10'h002;
      else if (macM[2] && att == 2) es = 10'h000;
      else es = rnd & ((10'h001 << ((att < 10) ? att : 10)) - 10'h001);
      bp = flwM[6] & ~dupM();
      cnt = bp ? ((cnt < 63) ? cnt + 1 : cnt) : 0;
      ej = bp && !macM[6] && cnt >= jamM;
      if (ej) cnt = 0;
      `CHK("slots", es, sl)
      `CHK("leak", ej, lk)
    end else begin
      ej = macM[3] && (frType != TAG_TYPE
           || (frVid != hostVid && frVid != NULL_VID));
      `CHK("reject", ej, rj)
    end
  endtask : fire

  always @(posedge busHung) begin
    badCount++;
    reportAndStop();
  end

  initial begin
    #900us;
    badCount++;
    reportAndStop();
  end

  initial begin
    {sysRst, seed} = {1'b1, 32'd28};
    {rtDone, rpReady, inRst, pwrSave, cfgLoad, txCfgDup} = '0;
    {coll, txDone, frChk, byteOrder, rnd, phy} = '0;
    {frType, frVid, hostVid, badCount, nChecks, att, cnt} = '0;
    {jamM, frLM, frHM} = {8'h19, 8'h00, 8'h06};
    {flwM, macM} = {8'h07, 8'h00};
    repeat (10) @(negedge clk);
    sysRst = 1'b0;
    allChk();
    regWr(5'h05, 8'hA5);
    rdChk(5'h05, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      r = xs();
      u_host.gap = i % 3;
      txCfgDup = i[2];
      phy.fullDuplex = i[3];
      regWr(OFF_JAM_STATUS, r[15:8]);
      regWr(OFF_FRAME_LOW, r[23:16]);
      regWr(OFF_FRAME_HIGH, r[31:24]);
      regWr(OFF_FLOW, r[14:7]);
      // test bits kept low as a host must in normal running
      regWr(OFF_MAC, {i[0], r[6:5], i[1], r[3], 3'b000});
      allChk();
    end
    u_host.gap = 0;
    $display("register writes done");
    for (int i = 0; i < 12; i++) begin
      r = xs();
      byteOrder = (r[3:0] == 4'h0) ? 8'h00 : r[15:8];
      {rtDone, rpReady, inRst, pwrSave, cfgLoad} = r[20:16];
      phy = r[23:21];
      rdChk(OFF_JAM_STATUS, {|byteOrder, rtDone, rpReady,
        ~(inRst | pwrSave | cfgLoad), 1'b0, phy});
    end
    {inRst, pwrSave, cfgLoad, phy.fullDuplex} = '0;
    $display("status done");
    regWr(OFF_MAC, 8'h00);
    regWr(OFF_FLOW, 8'h47);
    regWr(OFF_JAM_STATUS, 8'h02);
    repeat (4) fire(1'b1);
    regWr(OFF_JAM_STATUS, 8'h01);
    repeat (2) fire(1'b1);
    regWr(OFF_MAC, 8'h40);
    repeat (3) fire(1'b1);
    phy.fullDuplex = 1'b1;
    regWr(OFF_MAC, 8'h00);
    repeat (3) fire(1'b1);
    $display("leakage done");
    regWr(OFF_FLOW, 8'h07);
    for (int k = 0; k < 4; k++) begin
      regWr(OFF_MAC, modes[k]);
      txd();
      repeat ((k == 3) ? 12 : 4) fire(1'b1);
    end
    $display("back-off done");
    for (int i = 0; i < 8; i++) begin
      if (i % 4 == 0) regWr(OFF_MAC, (i == 0) ? 8'h08 : 8'h00);
      r = xs();
      hostVid = {r[11:1], 1'b1};
      frVid = (i % 4 == 0) ? hostVid
            : (i % 4 == 1) ? 12'h000 : hostVid ^ 12'h002;
      frType = (i % 4 == 3) ? 16'h0800 : TAG_TYPE;
      fire(1'b0);
    end
    $display("tag filter done");
    reportAndStop();
  end
endmodule : mfcs_regs_tb_top
